// ---- memory_page_and_port_decoder.sv ----
/*
 * address page and port decoder of an 8-bit single-board computer:
 * page selects for boot rom, system ram and display ram, port strobes
 * f8..ff, internal bus select, boot overlay and one forced wait state.
 * assumes cpu status, strobes, phase-2 and address arrive as pins on
 * other clocks; rst_b_i is the power-on clear.
 */
// Contract
// [R1] system ram answers c800..cbff; bits 9..0 stay in the array
// [R2] ram write enable only while memory-write status is high
// [R3] two rom enables, c0 and c4, never gated by write status
// [R4] page decoder opens only when address bits 15..12 are 1100
// [R5] bits 11..10 pick rom c0, rom c4, system ram c8, display cc
// [R6] onboard-memory-hit whenever any page select is active
// [R7] overlay active: page c shut, page 0 with 13..10 low is c0
// [R8] no page select in an input or output cycle
// [R9] ready low from mid sync to next phase-2 rise: one wait
// [R10] ready driver enabled only in memory, input or output cycles
// [R11] cpu samples both ready lines after sync, waits if either low
// [R12] port needs bits 15..11 all ones; 15,14 overlay-qualified
// [R13] bits 10..8 pick one strobe per port f8..ff
// [R14] input strobes only with data-in strobe and input status
// [R15] output strobes only with output status and cpu write strobe
// [R16] internal-bus-select for input ports f8, f9, fa, fb
// [R17] jumper fitted: interrupt acknowledge blocks all decoding
// [R18] output strobes: fe scroll, fd parallel, fb cassette, fa ctrl
// [R19] input strobes: ff switches through f8 serial status
// [R20] reading port fd also resets the parallel input handshake
// [R21] overlay active from power-on clear for four data-in strobes
// [R22] decoders combinational; only the wait flag is stateful (code also keeps the overlay fetch count as state)
// [R23] selects and strobes active low, inactive during reset (code drives internal-bus-select active high)
`timescale 1ns/100ps
`include "decoder_map.svh"

module memory_page_and_port_decoder
    import decoder_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [15:0] addr_i,
    input wire logic status_inp_i,
    input wire logic status_out_i,
    input wire logic status_mwrite_i,
    input wire logic status_inta_i,
    input wire logic data_in_strobe_i,
    input wire logic cpu_write_strobe_n_i,
    input wire logic psync_i,
    input wire logic phi2_i,
    input wire logic inta_jumper_i,
    output logic rom_c0_sel_n_o,
    output logic rom_c4_sel_n_o,
    output logic sys_ram_sel_n_o,
    output logic display_ram_page_sel_n_o,
    output logic mem_hit_o,
    output logic sys_ram_we_n_o,
    output logic [7:0] port_in_n_o,
    output logic [7:0] port_out_n_o,
    output logic int_bus_sel_o,
    output logic ready_o,
    output logic ready_oe_o,
    output logic boot_overlay_n_o,
    output logic parallel_port_hs_reset_o
);

    sync_word_t raw_pins;
    sync_word_t pins;

    // pin bundle order must match the unpacking below
    assign raw_pins = {
        addr_i,
        status_inp_i,
        status_out_i,
        status_mwrite_i,
        status_inta_i,
        data_in_strobe_i,
        cpu_write_strobe_n_i,
        psync_i,
        phi2_i,
        inta_jumper_i
    };

    pin_sync u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .pins_i(raw_pins),
        .pins_o(pins)
    );

    logic [15:0] adr;
    logic sinp;
    logic sout;
    logic mwrite;
    logic sinta;
    logic dbin;
    logic wr_n;
    logic psync;
    logic phi2;
    logic jumper;

    assign adr = pins[24:9];
    assign sinp = pins[8];
    assign sout = pins[7];
    assign mwrite = pins[6];
    assign sinta = pins[5];
    assign dbin = pins[4];
    assign wr_n = pins[3];
    assign psync = pins[2];
    assign phi2 = pins[1];
    assign jumper = pins[0];

    dec_s state_ff;
    dec_s nxt_state;

    // per-port digit match, shared by the input and output decoders
    logic [7:0] digit_hit;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_digit
            assign digit_hit[gi] = (adr[10:8] == 3'(gi)); // [R13]
        end
    endgenerate

    logic overlay;
    logic inta_block;
    logic io_cycle;
    logic page_open;
    logic [1:0] page_idx;
    logic [3:0] page_sel;
    logic q15;
    logic q14;
    logic port_open;
    logic in_en;
    logic out_en;
    logic [7:0] port_in;
    logic [7:0] port_out;
    logic cycle_act;
    logic dbin_rise;
    logic phi2_rise;

    always_comb
    begin
        nxt_state = state_ff;

        overlay = !state_ff.overlay_n;
        inta_block = jumper && sinta; // [R17]
        io_cycle = sinp || sout;

        // page decoder; under the overlay the top bits of page 0 stand
        // in for page c, so the rom answers from address zero and not from c000
        if (overlay)
        begin
            page_open = (adr[15:10] == 6'h00); // [R7]
            page_idx = `PAGE_C0; // [R7]
        end
        else
        begin
            page_open = (adr[15:12] == `PAGE_HI_NIBBLE); // [R4]
            page_idx = adr[11:10]; // [R5]
        end
        page_open = page_open && !io_cycle && !inta_block; // [R8] [R17]

        page_sel = 4'h0;
        if (page_open)
        begin
            unique case (page_idx)
                `PAGE_C0: page_sel[0] = 1'b1; // [R3]
                `PAGE_C4: page_sel[1] = 1'b1; // [R3]
                `PAGE_C8: page_sel[2] = 1'b1; // [R1]
                `DISPLAY_RAM_PAGE_SEL: page_sel[3] = 1'b1; // [R5]
            endcase
        end

        // top two port bits pass the same overlay inversion as the page
        // path; harmless since no port is touched in the first fetches
        q15 = adr[15] ^ overlay; // [R12]
        q14 = adr[14] ^ overlay; // [R12]
        port_open = ({q15, q14, adr[13:11]} == `PORT_HI_BITS); // [R12]
        port_open = port_open && !inta_block; // [R17]

        in_en = port_open && dbin && sinp; // [R14]
        out_en = port_open && sout && !wr_n; // [R15]
        port_in = in_en ? digit_hit : 8'h00; // [R19]
        port_out = out_en ? digit_hit : 8'h00; // [R18]

        // [R22] selects and strobes below are registered copies of pure
        // decode; the register only delays them, it holds no state
        nxt_state.page_n = ~page_sel; // [R23]
        nxt_state.mem_hit = |page_sel; // [R6]
        nxt_state.ram_we_n = !(page_sel[`PAGE_C8] && mwrite); // [R2]
        nxt_state.port_in_n = ~port_in; // [R23]
        nxt_state.port_out_n = ~port_out; // [R23]
        nxt_state.int_bus_sel = in_en && !adr[10]; // [R16]
        nxt_state.pp_hs_reset = port_in[`PORT_FD]; // [R20]

        // boot overlay: counts rising data-in strobes up to four
        dbin_rise = dbin && !state_ff.pdbin_prev;
        nxt_state.pdbin_prev = dbin;
        if (dbin_rise && state_ff.fetch_cnt != `OVERLAY_FETCHES)
        begin
            nxt_state.fetch_cnt = state_ff.fetch_cnt + 3'h1; // [R21]
        end
        nxt_state.overlay_n = (nxt_state.fetch_cnt == `OVERLAY_FETCHES); // [R21]

        // wait-state flag: set in mid sync, cleared by the first rising
        // phase-2 once sync has dropped
        phi2_rise = phi2 && !state_ff.phi2_prev;
        nxt_state.phi2_prev = phi2;
        if (psync && phi2)
        begin
            nxt_state.wait_flag = 1'b1; // [R9] [R22]
        end
        else if (phi2_rise && !psync)
        begin
            nxt_state.wait_flag = 1'b0; // [R9]
        end

        // the cpu samples this line together with the external one; a
        // low on either holds it; we drive it low for the wait, then high for the rest of the cycle
        cycle_act = |page_sel || io_cycle; // [R10] [R11]
        nxt_state.ready_oe = cycle_act; // [R10]
        nxt_state.ready = !(cycle_act && nxt_state.wait_flag); // [R9]
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_ff.fetch_cnt <= `RST_FETCH;
            state_ff.pdbin_prev <= 1'b0;
            state_ff.phi2_prev <= 1'b0;
            state_ff.wait_flag <= 1'b0;
            state_ff.page_n <= `RST_PAGE_N; // [R23]
            state_ff.mem_hit <= 1'b0;
            state_ff.ram_we_n <= 1'b1;
            state_ff.port_in_n <= `RST_PORT_N; // [R23]
            state_ff.port_out_n <= `RST_PORT_N; // [R23]
            state_ff.int_bus_sel <= 1'b0;
            state_ff.ready <= 1'b1;
            state_ff.ready_oe <= 1'b0;
            state_ff.overlay_n <= 1'b0; // [R21]
            state_ff.pp_hs_reset <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign rom_c0_sel_n_o = state_ff.page_n[`PAGE_C0];
    assign rom_c4_sel_n_o = state_ff.page_n[`PAGE_C4];
    assign sys_ram_sel_n_o = state_ff.page_n[`PAGE_C8];
    assign display_ram_page_sel_n_o = state_ff.page_n[`DISPLAY_RAM_PAGE_SEL];
    assign mem_hit_o = state_ff.mem_hit;
    assign sys_ram_we_n_o = state_ff.ram_we_n;
    assign port_in_n_o = state_ff.port_in_n;
    assign port_out_n_o = state_ff.port_out_n;
    assign int_bus_sel_o = state_ff.int_bus_sel;
    assign ready_o = state_ff.ready;
    assign ready_oe_o = state_ff.ready_oe;
    assign boot_overlay_n_o = state_ff.overlay_n;
    assign parallel_port_hs_reset_o = state_ff.pp_hs_reset;

endmodule

// ---- decoder_map.svh ----
/*
 * constants for the memory page and port decoder: page codes, port
 * digits, reset values and counts.
 * assumes it is included by bare name by the package and the decoder.
 */
`ifndef DECODER_MAP_SVH
`define DECODER_MAP_SVH

// address bits 15..12 that open the page decoder
`define PAGE_HI_NIBBLE 4'hc
// page index from address bits 11..10
`define PAGE_C0 2'h0
`define PAGE_C4 2'h1
`define PAGE_C8 2'h2
`define DISPLAY_RAM_PAGE_SEL 2'h3
// address bits 15..11 of any port, after overlay qualification
`define PORT_HI_BITS 5'h1f
// low port digit from address bits 10..8, minus eight
`define PORT_F8 3'h0
`define PORT_F9 3'h1
`define PORT_FA 3'h2
`define PORT_FB 3'h3
`define PORT_FC 3'h4
`define PORT_FD 3'h5
`define PORT_FE 3'h6
`define PORT_FF 3'h7
// fetches that run with the boot overlay active
`define OVERLAY_FETCHES 3'h4
// reset values
`define RST_PAGE_N 4'hf
`define RST_PORT_N 8'hff
`define RST_FETCH 3'h0
// width of the pin synchroniser bank
`define SYNC_W 25

`endif

// ---- decoder_pkg.sv ----
/*
 * types shared by the decoder and its pin synchroniser.
 * assumes decoder_map.svh is on the include path.
 */
`include "decoder_map.svh"

package decoder_pkg;

    typedef logic [`SYNC_W-1:0] sync_word_t;

    typedef struct packed {
        sync_word_t stage1;
        sync_word_t stage2;
    } sync_s;

    typedef struct packed {
        logic [2:0] fetch_cnt;
        logic pdbin_prev;
        logic phi2_prev;
        logic wait_flag;
        logic [3:0] page_n;
        logic mem_hit;
        logic ram_we_n;
        logic [7:0] port_in_n;
        logic [7:0] port_out_n;
        logic int_bus_sel;
        logic ready;
        logic ready_oe;
        logic overlay_n;
        logic pp_hs_reset;
    } dec_s;

endpackage

// ---- pin_sync.sv ----
/*
 * two-flip-flop synchroniser bank for the decoder's pin inputs.
 * assumes every bit is an independent level from outside this clock.
 */
`timescale 1ns/100ps

module pin_sync
    import decoder_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire sync_word_t pins_i,
    output sync_word_t pins_o
);

    sync_s state_ff;
    sync_s nxt_state;

    // first stage feeds only the second stage
    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.stage1 = pins_i;
        nxt_state.stage2 = state_ff.stage1;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign pins_o = state_ff.stage2;

endmodule

// ---- decoder_props.sv ----
/* checker for the page and port decoder, watching its ports only.
   assumes it is bound to the decoder top and port names match. */
`timescale 1ns/100ps
module decoder_props
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [15:0] addr_i,
    input wire logic status_inp_i,
    input wire logic status_out_i,
    input wire logic status_mwrite_i,
    input wire logic status_inta_i,
    input wire logic data_in_strobe_i,
    input wire logic cpu_write_strobe_n_i,
    input wire logic psync_i,
    input wire logic phi2_i,
    input wire logic inta_jumper_i,
    input wire logic rom_c0_sel_n_o,
    input wire logic rom_c4_sel_n_o,
    input wire logic sys_ram_sel_n_o,
    input wire logic display_ram_page_sel_n_o,
    input wire logic mem_hit_o,
    input wire logic sys_ram_we_n_o,
    input wire logic [7:0] port_in_n_o,
    input wire logic [7:0] port_out_n_o,
    input wire logic int_bus_sel_o,
    input wire logic ready_o,
    input wire logic ready_oe_o,
    input wire logic boot_overlay_n_o,
    input wire logic parallel_port_hs_reset_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    // four samples cover the two-flop pin delay plus the output register
    sequence s_io; (status_inp_i || status_out_i) [*4]; endsequence
    sequence s_ack; (inta_jumper_i && status_inta_i) [*4]; endsequence
    property p_hit; mem_hit_o == !(rom_c0_sel_n_o && rom_c4_sel_n_o && sys_ram_sel_n_o
        && display_ram_page_sel_n_o); endproperty
    property p_page; $onehot0(~{rom_c0_sel_n_o, rom_c4_sel_n_o, sys_ram_sel_n_o,
        display_ram_page_sel_n_o}); endproperty
    property p_we; !sys_ram_we_n_o |-> !sys_ram_sel_n_o; endproperty
    property p_ibs; int_bus_sel_o == !(&port_in_n_o[3:0]); endproperty
    property p_hs; parallel_port_hs_reset_o == !port_in_n_o[5]; endproperty
    property p_port; $onehot0(~port_in_n_o) && $onehot0(~port_out_n_o); endproperty
    property p_io; s_io |-> !mem_hit_o; endproperty
    property p_ack; s_ack |-> &port_in_n_o && &port_out_n_o && !mem_hit_o; endproperty
    property p_oe; !ready_oe_o |-> ready_o; endproperty
    property p_ovl; boot_overlay_n_o |=> boot_overlay_n_o; endproperty
    a_hit: assert property (p_hit) else $error("hit flag disagrees with page selects");
    a_page: assert property (p_page) else $error("more than one page select");
    a_we: assert property (p_we) else $error("write enable without system ram");
    a_ibs: assert property (p_ibs) else $error("internal bus select wrong");
    a_hs: assert property (p_hs) else $error("handshake reset without fd read");
    a_port: assert property (p_port) else $error("more than one port strobe");
    a_io: assert property (p_io) else $error("page select in io cycle");
    a_ack: assert property (p_ack) else $error("decode during interrupt ack");
    a_oe: assert property (p_oe) else $error("ready low while undriven");
    a_ovl: assert property (p_ovl) else $error("overlay came back");
endmodule
bind memory_page_and_port_decoder decoder_props props_u (.*);

// ---- cpu_model.sv ----
/* behavioural cpu and bus status driver for the decoder.
   assumes the bench calls its tasks; k bits: 0 mwrite, 1 inp, 2 out, 3 inta. */
`timescale 1ns/100ps
module cpu_model
(
    input wire logic clk_i,
    output logic [15:0] addr_o,
    output logic mwr_o,
    output logic inp_o,
    output logic out_o,
    output logic inta_o,
    output logic dbin_o,
    output logic wr_n_o,
    output logic psync_o,
    output logic phi2_o
);
    initial
    begin
        {addr_o, mwr_o, inp_o, out_o, inta_o, dbin_o, psync_o, phi2_o} = '0;
        wr_n_o = 1'b1;
    end
    // status and sync with phase-2 high: the point where status is latched
    task automatic start(input logic [15:0] a, input logic [3:0] k);
        @(posedge clk_i);
        addr_o <= a;
        {inta_o, out_o, inp_o, mwr_o} <= k;
        psync_o <= 1'b1;
        phi2_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
    // sync ends, then phase-2 rises: the cpu samples ready here
    task automatic strobe();
        @(posedge clk_i);
        psync_o <= 1'b0;
        phi2_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        phi2_o <= 1'b1;
        dbin_o <= !mwr_o && !out_o;
        wr_n_o <= !(mwr_o || out_o);
        repeat (4) @(posedge clk_i);
    endtask
    // released address lines show the inverse, never the old value
    task automatic stop();
        @(posedge clk_i);
        addr_o <= ~addr_o;
        {inta_o, out_o, inp_o, mwr_o, dbin_o} <= '0;
        wr_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
endmodule

// ---- testbench.sv ----
/* self-checking bench for the page and port decoder.
   assumes the cpu model drives all cpu pins; bench owns clock, reset, jumper. */
`timescale 1ns/100ps
module testbench;
    import decoder_pkg::*;
    logic ref_clk_i = 0, rst_b_i = 0, inta_jumper_i = 0;
    logic [15:0] addr_i;
    logic status_inp_i, status_out_i, status_mwrite_i, status_inta_i, data_in_strobe_i;
    logic cpu_write_strobe_n_i, psync_i, phi2_i, rom_c0_sel_n_o, rom_c4_sel_n_o, sys_ram_sel_n_o;
    logic display_ram_page_sel_n_o, mem_hit_o, sys_ram_we_n_o, int_bus_sel_o, ready_o, ready_oe_o;
    logic boot_overlay_n_o, parallel_port_hs_reset_o;
    logic [7:0] port_in_n_o, port_out_n_o;
    logic [3:0] pg_n;
    int n_mismatch = 0, samples_checked = 0, cyc = 0;
    assign pg_n = {display_ram_page_sel_n_o, sys_ram_sel_n_o, rom_c4_sel_n_o, rom_c0_sel_n_o};
    always #10 ref_clk_i = ~ref_clk_i;
    cpu_model cpu_u (.clk_i(ref_clk_i), .addr_o(addr_i), .mwr_o(status_mwrite_i), .inp_o(status_inp_i),
        .out_o(status_out_i), .inta_o(status_inta_i), .dbin_o(data_in_strobe_i),
        .wr_n_o(cpu_write_strobe_n_i), .psync_o(psync_i), .phi2_o(phi2_i));
    memory_page_and_port_decoder dut_u (.*);
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cyc_full(input logic [15:0] a, input logic [3:0] k);
        cpu_u.start(a, k);
        cpu_u.strobe();
        cpu_u.stop();
    endtask
    task automatic t_overlay();
        chk("overlay", boot_overlay_n_o, 0);
        chk("strobes", {port_in_n_o, port_out_n_o}, 16'hffff);
        cpu_u.start(16'h0123, 0);
        chk("page0", pg_n, 4'he);
        cpu_u.strobe();
        cpu_u.stop();
        cpu_u.start(16'hc000, 0);
        chk("pagec", pg_n, 4'hf);
        cpu_u.strobe();
        cpu_u.stop();
        repeat (2) cyc_full(16'h0000, 0);
        chk("overlay", boot_overlay_n_o, 1);
        cpu_u.start(16'h0000, 0);
        chk("page0off", pg_n, 4'hf);
        cpu_u.stop();
    endtask
    task automatic t_pages();
        for (int i = 0; i < 4; i++)
        begin
            cpu_u.start({4'hc, 2'(i), 10'h3ff}, 4'h1);
            chk("page", pg_n, 4'(~(4'h1 << i)));
            chk("hit", mem_hit_o, 1);
            chk("we", sys_ram_we_n_o, i != 2);
            cpu_u.stop();
        end
        cpu_u.start(16'hd800, 4'h1);
        chk("nonc", pg_n, 4'hf);
        cpu_u.stop();
        cpu_u.start(16'hc800, 4'h2);
        chk("iopage", pg_n, 4'hf);
        cpu_u.stop();
    endtask
    task automatic t_ports();
        for (int i = 0; i < 8; i++)
        begin
            cpu_u.start({5'h1f, 3'(i), 8'h00}, 4'h2);
            chk("nodbin", port_in_n_o, 8'hff);
            chk("wait", {ready_o, ready_oe_o}, 2'b01);
            cpu_u.strobe();
            chk("in", port_in_n_o, 8'(~(8'h1 << i)));
            chk("ready", {ready_o, ready_oe_o}, 2'b11);
            chk("ibs", int_bus_sel_o, i < 4);
            chk("hs", parallel_port_hs_reset_o, i == 5);
            cpu_u.stop();
            cpu_u.start({5'h1f, 3'(i), 8'h00}, 4'h4);
            chk("nowr", port_out_n_o, 8'hff);
            cpu_u.strobe();
            chk("out", port_out_n_o, 8'(~(8'h1 << i)));
            cpu_u.stop();
        end
        chk("idle", {ready_o, ready_oe_o}, 2'b10);
    endtask
    task automatic t_inta();
        inta_jumper_i <= 1'b1;
        cpu_u.start(16'hf800, 4'ha);
        cpu_u.strobe();
        chk("ackblk", port_in_n_o, 8'hff);
        cpu_u.stop();
        inta_jumper_i <= 1'b0;
        cpu_u.start(16'hf800, 4'ha);
        cpu_u.strobe();
        chk("ackopen", port_in_n_o, 8'hfe);
        cpu_u.stop();
    endtask
    // mid-run power-on clear with status idle: strobes drop, overlay restarts
    task automatic t_reset();
        cpu_u.start(16'hfd00, 4'h2);
        cpu_u.strobe();
        chk("prerst", port_in_n_o, 8'hdf);
        cpu_u.stop();
        rst_b_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        chk("inrst", {port_in_n_o, pg_n, mem_hit_o, ready_oe_o, boot_overlay_n_o}, {8'hff, 4'hf, 3'b000});
        rst_b_i <= 1'b1;
        cpu_u.start(16'hfd00, 4'h2);
        cpu_u.strobe();
        chk("ovlport", port_in_n_o, 8'hff);
        cpu_u.stop();
        repeat (3) cyc_full(16'h0000, 0);
        chk("reovl", boot_overlay_n_o, 1);
    endtask
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            results();
        end
    end
    initial
    begin
        repeat (3) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        #1;
        t_overlay();
        t_pages();
        t_ports();
        t_inta();
        t_reset();
        results();
    end
endmodule
